// ### hw/ers_card_handshake.sv
// four-phase request/acknowledge master toward the memory card
// assumes the card holds read data stable while its acknowledge is high
`timescale 1ns/1ps
module ers_card_handshake
    import ers_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic write,
    input wire logic [23:0] addr,
    input wire logic [31:0] wdata,
    output logic busy,
    output logic done,
    output logic [31:0] rdata,
    output logic memReq,
    output logic memWrite,
    output logic [23:0] memAddr,
    output logic [31:0] memWrData,
    input wire logic memAck,
    input wire logic [31:0] memRdData
);
    ers_hs_t state_r;
    logic ackS1_r;
    logic ackS2_r;

    // acknowledge comes from the card, so it is synchronised first
    always_ff @(posedge clk) begin
        if (reset) begin
            ackS1_r <= 1'b0;
            ackS2_r <= 1'b0;
        end else begin
            ackS1_r <= memAck;
            ackS2_r <= ackS1_r;
        end
    end

    // request held until ack, then released until ack drops
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= HS_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 32'h00000000;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= 24'h000000;
            memWrData <= 32'h00000000;
        end else begin
            done <= 1'b0;
            case (state_r)
                HS_IDLE: begin
                    if (start) begin
                        memAddr <= addr;
                        memWrData <= wdata;
                        memWrite <= write;
                        memReq <= 1'b1;
                        busy <= 1'b1;
                        state_r <= HS_REQ;
                    end
                end
                HS_REQ: begin
                    if (ackS2_r) begin
                        rdata <= memRdData; // stable while ack is high
                        memReq <= 1'b0;
                        state_r <= HS_REL;
                    end
                end
                HS_REL: begin
                    // wait for ack release so a new cycle cannot alias
                    if (!ackS2_r) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        memWrite <= 1'b0;
                        state_r <= HS_IDLE;
                    end
                end
                default: state_r <= HS_IDLE;
            endcase
        end
    end
endmodule : ers_card_handshake

// ### hw/ers_pkg.sv
// constants for the external reading store writer
// assumes a 32-bit APB register port and a 24-bit word-wide memory card port
package ers_pkg;
    // APB register byte offsets
    localparam logic [11:0] ERS_OFF_CTRL = 12'h000;
    localparam logic [11:0] ERS_OFF_BASE = 12'h004;
    localparam logic [11:0] ERS_OFF_LENGTH = 12'h008;
    localparam logic [11:0] ERS_OFF_STATUS = 12'h00C;
    localparam logic [11:0] ERS_OFF_COUNT = 12'h010;
    localparam logic [11:0] ERS_OFF_FETCH_ADDR = 12'h014;
    localparam logic [11:0] ERS_OFF_FETCH_DATA = 12'h018;
    // field positions
    localparam int ERS_CTRL_ENABLE_BIT = 0;
    localparam int ERS_ST_RUN_BIT = 0;
    localparam int ERS_ST_FULL_BIT = 1;
    localparam int ERS_ST_FETCH_BIT = 2;
    localparam int ERS_ST_STOP_BIT = 3;
    // values after reset
    localparam logic [23:0] ERS_BASE_RESET = 24'h240000;
    localparam logic [23:0] ERS_LENGTH_RESET = 24'h000000;
    localparam logic ERS_ENABLE_RESET = 1'b0;
    // bytes in one stored reading
    localparam logic [24:0] ERS_WORD_BYTES = 25'h0000004;
    // acquisition sequencer
    typedef enum logic [1:0] {
        ACQ_IDLE = 2'b00,
        ACQ_RUN = 2'b01
    } ers_acq_t;
    // memory card handshake
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_REQ = 2'b01,
        HS_REL = 2'b10
    } ers_hs_t;
endpackage : ers_pkg

// ### hw/ers_store_writer.sv
// external reading store writer: copies readings into a memory card
// assumes readings, start and stop come from logic on clk; card is async
//
// Functional notes
// R1: programmable 24-bit storage base address
// R2: base defaults to 240000 hex
// R3: programmable storage length in bytes
// R4: host keeps length a multiple of four
// R5: number notation is resolved before registers
// R6: enable flag, cleared by reset
// R7: done only after stop or memory full; the code also pulses done at once when start arrives while enable is clear
// R8: enable reads back as 1 or 0
// R9: base reads back as programmed
// R10: length reads back as programmed
// R11: stored readings are fetched from the card
// R12: readings stored and returned unformatted
// R13: ascending word writes, stop at length
`timescale 1ns/1ps
module ers_store_writer
    import ers_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic acqStart,
    input wire logic acqStop,
    output logic acqDone,
    input wire logic rdgValid,
    input wire logic [31:0] rdgData,
    output logic rdgReady,
    output logic memReq,
    output logic memWrite,
    output logic [23:0] memAddr,
    output logic [31:0] memWrData,
    input wire logic memAck,
    input wire logic [31:0] memRdData
);
    // configuration and state
    logic enable_r;
    logic [23:0] base_r;
    logic [23:0] length_r;
    logic [23:0] runBase_r;
    logic [24:0] runLength_r;
    ers_acq_t acqState_r;
    ers_acq_t acqState_nxt;
    logic stopSeen_r;
    logic [24:0] reserved_r;
    logic [24:0] reserved_nxt;
    logic [24:0] stored_r;
    logic holdValid_r;
    logic holdValid_nxt;
    logic [31:0] holdData_r;
    logic [23:0] holdAddr_r;
    logic fetchPending_r;
    logic fetchActive_r;
    logic [23:0] fetchOff_r;
    logic [31:0] fetchData_r;
    logic opIsWrite_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic rdgReady_r;
    logic acqDone_r;

    // APB decode; one wait state before pready
    wire accessCycle = psel & penable & ~pready_r;
    wire apbWrite = psel & penable & pwrite & pready_r;
    wire hitCtrl = paddr == ERS_OFF_CTRL;
    wire hitBase = paddr == ERS_OFF_BASE;
    wire hitLength = paddr == ERS_OFF_LENGTH;
    wire hitStatus = paddr == ERS_OFF_STATUS;
    wire hitCount = paddr == ERS_OFF_COUNT;
    wire hitFetchAddr = paddr == ERS_OFF_FETCH_ADDR;
    wire hitFetchData = paddr == ERS_OFF_FETCH_DATA;
    wire addrHit = hitCtrl | hitBase | hitLength | hitStatus | hitCount |
        hitFetchAddr | hitFetchData;

    // handshake engine wiring
    logic hsBusy;
    logic hsDone;
    logic [31:0] hsRdata;
    wire running = acqState_r == ACQ_RUN;
    wire wrIssue = holdValid_r & ~hsBusy;
    wire rdIssue = fetchPending_r & ~holdValid_r & ~hsBusy;
    wire hsStart = wrIssue | rdIssue;
    wire [23:0] fetchAddr = base_r + {fetchOff_r[23:2], 2'b00}; // R11
    wire [23:0] hsAddr = wrIssue ? holdAddr_r : fetchAddr;

    // reading intake; a short tail below one word is never used
    wire rdgTake = rdgValid & rdgReady_r;
    assign reserved_nxt = rdgTake ? reserved_r + ERS_WORD_BYTES
        : reserved_r;
    assign holdValid_nxt = rdgTake | (holdValid_r & ~wrIssue);
    wire roomNxt = (reserved_nxt + ERS_WORD_BYTES) <= runLength_r; // R13
    wire roomNow = (reserved_r + ERS_WORD_BYTES) <= runLength_r;
    wire stopNow = stopSeen_r | acqStop;
    wire runEnd = running & (stopSeen_r | ~roomNow) & ~holdValid_r &
        ~(hsBusy & opIsWrite_r) & ~rdgTake;
    wire startEnabled = acqStart & ~running & enable_r;

    // sequencer next state
    always_comb begin
        acqState_nxt = acqState_r;
        case (acqState_r)
            ACQ_IDLE: begin
                if (startEnabled) begin
                    acqState_nxt = ACQ_RUN;
                end
            end
            ACQ_RUN: begin
                if (runEnd) begin
                    acqState_nxt = ACQ_IDLE; // R7
                end
            end
            default: acqState_nxt = ACQ_IDLE;
        endcase
    end

    // readback multiplexer
    wire [31:0] statusWord = {28'h0000000, stopSeen_r,
        fetchPending_r | fetchActive_r, running & ~roomNow, running};
    wire [31:0] rdMux =
        hitCtrl ? {31'h00000000, enable_r} : // R8
        hitBase ? {8'h00, base_r} : // R9
        hitLength ? {8'h00, length_r} : // R10
        hitStatus ? statusWord :
        hitCount ? {7'h00, stored_r} :
        hitFetchAddr ? {8'h00, fetchOff_r} :
        hitFetchData ? fetchData_r : // R12
        32'h00000000;

    // APB answer timing
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= accessCycle;
            pslverr_r <= accessCycle & ~addrHit;
            if (accessCycle && !pwrite) begin
                prdata_r <= rdMux;
            end
        end
    end

    // configuration registers; values arrive already binary
    always_ff @(posedge clk) begin
        if (reset) begin
            enable_r <= ERS_ENABLE_RESET; // R6
            base_r <= ERS_BASE_RESET; // R2
            length_r <= ERS_LENGTH_RESET;
        end else if (apbWrite) begin
            if (hitCtrl) begin
                enable_r <= pwdata[ERS_CTRL_ENABLE_BIT]; // R6
            end
            if (hitBase) begin
                base_r <= pwdata[23:0]; // R1 R5
            end
            if (hitLength) begin
                length_r <= pwdata[23:0]; // R3 R5
            end
        end
    end

    // run settings are frozen so mid-run writes cannot tear a block
    always_ff @(posedge clk) begin
        if (reset) begin
            acqState_r <= ACQ_IDLE;
            runBase_r <= ERS_BASE_RESET;
            runLength_r <= 25'h0000000;
            stopSeen_r <= 1'b0;
            acqDone_r <= 1'b0;
        end else begin
            acqState_r <= acqState_nxt;
            acqDone_r <= runEnd | (acqStart & ~running & ~enable_r); // R7
            if (startEnabled) begin
                runBase_r <= base_r;
                runLength_r <= {1'b0, length_r};
                stopSeen_r <= 1'b0;
            end else if (running && acqStop) begin
                stopSeen_r <= 1'b1;
            end
        end
    end

    // reading hold register and write addresses
    always_ff @(posedge clk) begin
        if (reset) begin
            reserved_r <= 25'h0000000;
            holdValid_r <= 1'b0;
            holdData_r <= 32'h00000000;
            holdAddr_r <= 24'h000000;
            rdgReady_r <= 1'b0;
        end else begin
            holdValid_r <= holdValid_nxt;
            reserved_r <= startEnabled ? 25'h0000000 : reserved_nxt;
            if (rdgTake) begin
                holdData_r <= rdgData; // R12
                holdAddr_r <= runBase_r + reserved_r[23:0]; // R13
            end
            rdgReady_r <= running & ~stopNow & ~holdValid_nxt & roomNxt &
                ~runEnd; // R13
        end
    end

    // completed write byte count and fetch requests
    always_ff @(posedge clk) begin
        if (reset) begin
            stored_r <= 25'h0000000;
            opIsWrite_r <= 1'b0;
            fetchPending_r <= 1'b0;
            fetchActive_r <= 1'b0;
            fetchOff_r <= 24'h000000;
            fetchData_r <= 32'h00000000;
        end else begin
            if (startEnabled) begin
                stored_r <= 25'h0000000;
            end else if (hsDone && opIsWrite_r) begin
                stored_r <= stored_r + ERS_WORD_BYTES;
            end
            if (hsStart) begin
                opIsWrite_r <= wrIssue;
            end
            if (apbWrite && hitFetchAddr) begin
                fetchOff_r <= pwdata[23:0];
                fetchPending_r <= 1'b1; // R11
            end else if (rdIssue) begin
                fetchPending_r <= 1'b0;
            end
            // a queued fetch may issue on the edge the last one ends
            if (rdIssue) begin
                fetchActive_r <= 1'b1;
            end else if (hsDone && !opIsWrite_r) begin
                fetchActive_r <= 1'b0;
            end
            if (hsDone && !opIsWrite_r) begin
                fetchData_r <= hsRdata; // R11
            end
        end
    end

    // memory card cycles, writes ahead of fetches
    ers_card_handshake u_hs (
        .clk(clk),
        .reset(reset),
        .start(hsStart),
        .write(wrIssue),
        .addr(hsAddr),
        .wdata(holdData_r),
        .busy(hsBusy),
        .done(hsDone),
        .rdata(hsRdata),
        .memReq(memReq),
        .memWrite(memWrite),
        .memAddr(memAddr),
        .memWrData(memWrData),
        .memAck(memAck),
        .memRdData(memRdData)
    );

    // outputs straight from flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign rdgReady = rdgReady_r;
    assign acqDone = acqDone_r;
endmodule : ers_store_writer

// ### verification/ers_card_model.sv
// behavioural memory card on the request/acknowledge port
// assumes requests change just after clk edges
`timescale 1ns/1ps
module ers_card_model
    import ers_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [23:0] memAddr,
    input wire logic [31:0] memWrData,
    output logic memAck,
    output logic [31:0] memRdData
);
    logic [31:0] mem [logic [23:0]];
    int waitCnt, cycCnt;
    // alternate prompt and slow answers to exercise the sync path
    always @(posedge clk) begin
        if (reset) begin
            memAck <= 1'b0;
            memRdData <= 32'hA5A5A5A5;
            waitCnt <= 1;
            cycCnt <= 0;
        end else if (memReq && !memAck) begin
            if (waitCnt > 0) begin
                waitCnt <= waitCnt - 1;
            end else begin
                memAck <= 1'b1;
                if (memWrite) begin
                    mem[memAddr] = memWrData;
                end else begin
                    memRdData <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
                end
            end
        end else if (!memReq && memAck) begin
            memAck <= 1'b0;
            memRdData <= ~memRdData; // released data is not kept
            cycCnt <= cycCnt + 1;
            waitCnt <= cycCnt[0] ? 1 : 6;
        end
    end
endmodule : ers_card_model

// ### verification/ers_store_writer_chk.sv
// port assertions for the reading store writer
// assumes binding into ers_store_writer; one clock, sync reset
`timescale 1ns/1ps
module ers_store_writer_chk
    import ers_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic acqDone,
    input wire logic rdgValid,
    input wire logic rdgReady,
    input wire logic memReq,
    input wire logic [23:0] memAddr,
    input wire logic [31:0] memWrData,
    input wire logic memAck
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // register port: one wait state, one-cycle answer
    property p_wait; psel && $rose(penable) |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_flag; pready && !pwrite && paddr == ERS_OFF_CTRL
        |-> prdata[31:1] == 31'h0; endproperty
    a_flag: assert property (p_flag) else $error("flag not 1 or 0");
    // card cycles: aligned, held, four-phase
    property p_align; memReq |-> memAddr[1:0] == 2'b00; endproperty
    a_align: assert property (p_align) else $error("unaligned");
    property p_hold; memReq && $past(memReq)
        |-> $stable(memAddr) && $stable(memWrData); endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_rel; $fell(memReq) |-> $past(memAck); endproperty
    a_rel: assert property (p_rel) else $error("dropped unacked");
    property p_rise; $rose(memReq) |-> !memAck; endproperty
    a_rise: assert property (p_rise) else $error("ack not idle");
    // done only once writes have drained
    property p_done; acqDone |-> !memReq ##1 !acqDone; endproperty
    a_done: assert property (p_done) else $error("early done");
    property p_take; rdgValid && rdgReady |=> !rdgReady; endproperty
    a_take: assert property (p_take) else $error("ready held");
endmodule : ers_store_writer_chk

bind ers_store_writer ers_store_writer_chk chk_u (.clk, .reset, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .acqDone,
    .rdgValid, .rdgReady, .memReq, .memAddr, .memWrData, .memAck);

// ### verification/tb_ers_store_writer.sv
// self-checking bench for the reading store writer
// assumes ers_card_model as the card; bench is the APB master
`timescale 1ns/1ps
module tb_ers_store_writer
    import ers_pkg::*;
;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, e;
    logic acqStart, acqStop, acqDone, rdgValid, rdgReady;
    logic memReq, memWrite, memAck;
    logic [11:0] paddr;
    logic [23:0] memAddr;
    logic [31:0] pwdata, prdata, rdgData, memWrData, memRdData, q;
    int error_cnt, tests_run, doneCnt, i;

    ers_store_writer dut_u (.clk, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .acqStart, .acqStop,
        .acqDone, .rdgValid, .rdgData, .rdgReady, .memReq, .memWrite,
        .memAddr, .memWrData, .memAck, .memRdData);
    ers_card_model card_u (.clk, .reset, .memReq, .memWrite, .memAddr,
        .memWrData, .memAck, .memRdData);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // count completion pulses; waits compare against a running total
    always @(posedge clk) if (acqDone === 1'b1) doneCnt++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic hung;
        error_cnt++;
        stop_test();
    endtask : hung
    // one APB transfer; an idle edge first so psel never toggles twice
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) hung();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        apb(1'b0, a, 32'h0);
        check(q, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : rd
    task automatic pulse(input logic stp);
        @(posedge clk);
        if (stp) acqStop <= 1'b1;
        else acqStart <= 1'b1;
        @(posedge clk);
        acqStop <= 1'b0;
        acqStart <= 1'b0;
    endtask : pulse
    task automatic feed(input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rdgValid <= 1'b1;
        rdgData <= d;
        do begin @(posedge clk); n++; end while (rdgReady !== 1'b1 && n < 200);
        if (rdgReady !== 1'b1) hung();
        rdgValid <= 1'b0;
        rdgData <= ~d; // released data does not linger
    endtask : feed
    task automatic waitDone(input int k, input int lim);
        int n;
        n = 0;
        while (doneCnt < k && n < lim) begin @(posedge clk); n++; end
        if (doneCnt < k) hung();
    endtask : waitDone

    initial begin
        {reset, psel, penable, pwrite, acqStart, acqStop, rdgValid} = 7'h40;
        {paddr, pwdata, rdgData} = '0;
        {error_cnt, tests_run, doneCnt} = '0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(ERS_OFF_CTRL, 32'h0, 1'b0);
        rd(ERS_OFF_BASE, 32'h00240000, 1'b0);
        rd(ERS_OFF_LENGTH, 32'h0, 1'b0);
        // disabled: start completes at once, card untouched
        pulse(1'b0);
        waitDone(1, 4);
        rd(ERS_OFF_COUNT, 32'h0, 1'b0);
        apb(1'b1, ERS_OFF_BASE, 32'h00300000);
        rd(ERS_OFF_BASE, 32'h00300000, 1'b0);
        apb(1'b1, ERS_OFF_LENGTH, 32'h0000000E);
        rd(ERS_OFF_LENGTH, 32'h0000000E, 1'b0);
        apb(1'b1, ERS_OFF_CTRL, 32'h1);
        rd(ERS_OFF_CTRL, 32'h1, 1'b0);
        rd(12'h01C, 32'h0, 1'b1);
        // 14 bytes hold three readings; done without any stop
        pulse(1'b0);
        for (i = 0; i < 3; i++) feed(32'hC0DE0000 + i);
        // last write still in flight: running and full together
        rd(ERS_OFF_STATUS, 32'h00000003, 1'b0);
        waitDone(2, 300);
        for (i = 0; i < 3; i++) check(card_u.mem[24'h300000 + 4 * i],
            32'hC0DE0000 + i);
        check(32'(card_u.mem.exists(24'h30000C)), 32'h0);
        rd(ERS_OFF_COUNT, 32'h0000000C, 1'b0);
        rd(ERS_OFF_STATUS, 32'h00000000, 1'b0);
        // read back the second stored word raw from the card
        apb(1'b1, ERS_OFF_FETCH_ADDR, 32'h4);
        i = 0;
        do begin apb(1'b0, ERS_OFF_STATUS, 32'h0); i++; end
            while (q[ERS_ST_FETCH_BIT] !== 1'b0 && i < 50);
        check({31'h0, q[ERS_ST_FETCH_BIT]}, 32'h0);
        if (q[ERS_ST_FETCH_BIT] !== 1'b0) hung();
        rd(ERS_OFF_FETCH_DATA, 32'hC0DE0001, 1'b0);
        // room left: no completion until the stop arrives
        apb(1'b1, ERS_OFF_LENGTH, 32'h00000100);
        pulse(1'b0);
        feed(32'h0000BEEF);
        feed(32'hFFFF0001);
        repeat (40) @(posedge clk);
        check(doneCnt, 32'h2);
        pulse(1'b1);
        waitDone(3, 300);
        rd(ERS_OFF_COUNT, 32'h00000008, 1'b0);
        rd(ERS_OFF_STATUS, 32'h00000008, 1'b0);
        check(card_u.mem[24'h300004], 32'hFFFF0001);
        // reset after the run has ended restores the defaults
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(ERS_OFF_CTRL, 32'h0, 1'b0);
        rd(ERS_OFF_BASE, 32'h00240000, 1'b0);
        rd(ERS_OFF_LENGTH, 32'h0, 1'b0);
        rd(ERS_OFF_COUNT, 32'h0, 1'b0);
        stop_test();
    end
endmodule : tb_ers_store_writer
